// file: design/ppc_port_block.sv
// four eight-bit ports with per-pin driver modes behind axi4-lite
`timescale 1ns/100ps
module ppc_port_block
  import ppc_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // port pins, index is port number
  input wire logic [3:0][7:0] pin_in,
  output logic [3:0][7:0] pin_out,
  output logic [3:0][7:0] pin_oe,
  output logic [3:0][7:0] pin_pu
);
  typedef struct packed {
    logic [3:0][7:0] latch;
    logic [3:0][7:0] cfg_lo;
    logic [3:0][7:0] cfg_hi;
    logic awready;
    logic aw_held;
    logic [5:0] aw_addr;
    logic wready;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ppc_state_type;

  ppc_state_type st_reg;
  ppc_state_type st_next;
  logic [7:0] rd_data;
  logic rd_hit;
  logic [3:0][7:0] pin_level;
  logic [3:0][7:0] avail;

  // pins missing on the small package read as zero and stay undriven
  always_comb begin
    for (int p = 0; p < PPC_PORTS; p++) begin
      avail[p] = PPC_ALL_PINS;
    end
    if (!LARGE_PACKAGE) begin
      avail[PPC_P3] = PPC_P3_SMALL_MASK;
    end
    for (int p = 0; p < PPC_PORTS; p++) begin
      pin_level[p] = pin_in[p] & avail[p];
    end
  end

  ppc_read_mux u_rd (
    .addr(araddr),
    .pin_level(pin_level),
    .cfg_lo(st_reg.cfg_lo),
    .cfg_hi(st_reg.cfg_hi),
    .data(rd_data),
    .hit(rd_hit)
  );

  // next-state: write path holds address and data until both arrive,
  // so the master may offer them in either order
  always_comb begin
    st_next = st_reg;
    if (awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = wdata[7:0];
      st_next.w_lane0 = wstrb[0];
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    // commit: only byte lane 0 carries register bits
    if (st_next.aw_held && st_next.w_held && !st_next.bvalid) begin
      st_next.bresp = PPC_RESP_SLVERR;
      for (int p = 0; p < PPC_PORTS; p++) begin
        if (st_next.aw_addr == PPC_LATCH_OFS[p]) begin
          st_next.bresp = PPC_RESP_OKAY;
          if (st_next.w_lane0) begin
            st_next.latch[p] = st_next.w_data;
          end
        end
        if (st_next.aw_addr == PPC_CFG_LO_OFS[p]) begin
          st_next.bresp = PPC_RESP_OKAY;
          if (st_next.w_lane0) begin
            st_next.cfg_lo[p] = st_next.w_data;
          end
        end
        if (st_next.aw_addr == PPC_CFG_HI_OFS[p]) begin
          st_next.bresp = PPC_RESP_OKAY;
          if (st_next.w_lane0) begin
            st_next.cfg_hi[p] = st_next.w_data;
          end
        end
      end
      st_next.bvalid = 1'b1;
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
    end
    // one write in flight: no new beat until the response is taken
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready = !st_next.w_held && !st_next.bvalid;
    // read path: one read in flight, data sampled at address handshake
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = {PPC_RDATA_PAD, rd_data};
      st_next.rresp = rd_hit ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
    end
    st_next.arready = !st_next.rvalid;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < PPC_PORTS; p++) begin
        st_reg.latch[p] <= PPC_LATCH_RST;
        st_reg.cfg_lo[p] <= PPC_CFG_LO_RST;
        st_reg.cfg_hi[p] <= PPC_CFG_HI_RST;
      end
      st_reg.awready <= 1'b1;
      st_reg.aw_held <= 1'b0;
      st_reg.aw_addr <= 6'h00;
      st_reg.wready <= 1'b1;
      st_reg.w_held <= 1'b0;
      st_reg.w_data <= 8'h00;
      st_reg.w_lane0 <= 1'b0;
      st_reg.bvalid <= 1'b0;
      st_reg.bresp <= PPC_RESP_OKAY;
      st_reg.arready <= 1'b1;
      st_reg.rvalid <= 1'b0;
      st_reg.rdata <= 32'h00000000;
      st_reg.rresp <= PPC_RESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // one registered driver per port, each on its own config pair
  for (genvar p = 0; p < PPC_PORTS; p++) begin : g_port
    ppc_pin_drive u_drv (
      .aclk(aclk),
      .aresetn(aresetn),
      .latch(st_reg.latch[p]),
      .cfg_lo(st_reg.cfg_lo[p]),
      .cfg_hi(st_reg.cfg_hi[p]),
      .pin_avail(avail[p]),
      .pin_out(pin_out[p]),
      .pin_oe(pin_oe[p]),
      .pin_pu(pin_pu[p])
    );
  end

  // bus outputs straight from the state register
  assign awready = st_reg.awready;
  assign wready = st_reg.wready;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = st_reg.arready;
  assign rvalid = st_reg.rvalid;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence

  sequence s_rd_take(logic [5:0] a);
    arvalid && arready && araddr == a;
  endsequence

  a_write_answer: assert property (
    s_wr_both |=> bvalid && !awready && !wready)
    else $error("write not answered one cycle after handshakes");

  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

  a_port0_latch: assert property (
    s_wr_both ##0 (awaddr == PPC_LATCH_OFS[0] && wstrb[0])
    |=> st_reg.latch[0] == $past(wdata[7:0]))
    else $error("port 0 latch not written");

  a_port1_read: assert property (
    s_rd_take(PPC_LATCH_OFS[1])
    |=> rvalid && rdata[7:0] == $past(pin_in[1]))
    else $error("port 1 read does not return pins");

  a_port2_read: assert property (
    s_rd_take(PPC_LATCH_OFS[2])
    |=> rvalid && rdata[7:0] == $past(pin_in[2]))
    else $error("port 2 read does not return pins");

  a_port3_drive: assert property (
    s_wr_both ##0 (awaddr == PPC_CFG_HI_OFS[3] && wstrb[0])
    |=> st_reg.cfg_hi[3] == $past(wdata[7:0]))
    else $error("port 3 config high not written");

  a_port3_small: assert property (
    !LARGE_PACKAGE |-> (pin_oe[PPC_P3] & ~PPC_P3_SMALL_MASK) == 8'h00)
    else $error("missing port 3 pin driven");

  a_latch_to_pin: assert property (
    st_reg.cfg_hi[0][0] && st_reg.cfg_lo[0][0]
    ##1 st_reg.cfg_hi[0][0] && st_reg.cfg_lo[0][0]
    |-> pin_oe[0][0] && pin_out[0][0] == $past(st_reg.latch[0][0]))
    else $error("push-pull pin does not follow latch");

  a_rresp_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");

  // one write and one read in flight: channels stay shut while answered
  a_aw_blocked: assert property (
    bvalid |-> !awready && !wready)
    else $error("write taken while response pending");

  a_ar_blocked: assert property (
    rvalid |-> !arready)
    else $error("read taken while data pending");

  a_read_answer: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered one cycle after address");

  a_write_reopen: assert property (
    bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not reopened after response");

  a_read_reopen: assert property (
    rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened after data");

  // only the low byte carries register bits, the rest reads as zero
  a_rdata_pad: assert property (
    rvalid |-> rdata[31:8] == PPC_RDATA_PAD)
    else $error("upper read data not zero");

  // unmapped reads must be flagged so software sees the mistake
  a_rd_unmapped: assert property (
    arvalid && arready && !rd_hit |=> rvalid && rresp == PPC_RESP_SLVERR)
    else $error("unmapped read not refused");

  a_rd_mapped: assert property (
    arvalid && arready && rd_hit |=> rvalid && rresp == PPC_RESP_OKAY)
    else $error("mapped read refused");

  // small package: missing port 3 pins neither drive nor read back
  a_small_quiet: assert property (
    !LARGE_PACKAGE
    |-> ((pin_pu[PPC_P3] | pin_out[PPC_P3]) & ~PPC_P3_SMALL_MASK) == 8'h00)
    else $error("missing port 3 pin pulled or driven");

  a_small_read: assert property (
    !LARGE_PACKAGE && arvalid && arready
    && araddr == PPC_LATCH_OFS[PPC_P3]
    |=> (rdata[7:0] & ~PPC_P3_SMALL_MASK) == 8'h00)
    else $error("missing port 3 pin read as one");

  // write of both beats at once to one address
  sequence s_wr_to(logic [5:0] a);
    s_wr_both ##0 (awaddr == a);
  endsequence

  // per port: every register takes lane 0, reads see pins or config
  for (genvar p = 0; p < PPC_PORTS; p++) begin : g_reg_chk
    a_latch_write: assert property (
      s_wr_to(PPC_LATCH_OFS[p]) ##0 wstrb[0]
      |=> st_reg.latch[p] == $past(wdata[7:0]))
      else $error("latch write lost");

    a_cfg_lo_write: assert property (
      s_wr_to(PPC_CFG_LO_OFS[p]) ##0 wstrb[0]
      |=> st_reg.cfg_lo[p] == $past(wdata[7:0]))
      else $error("config low write lost");

    a_cfg_hi_write: assert property (
      s_wr_to(PPC_CFG_HI_OFS[p]) ##0 wstrb[0]
      |=> st_reg.cfg_hi[p] == $past(wdata[7:0]))
      else $error("config high write lost");

    a_strb_keep: assert property (
      s_wr_both ##0 !wstrb[0]
      |=> $stable(st_reg.latch[p]) && $stable(st_reg.cfg_lo[p])
      && $stable(st_reg.cfg_hi[p]))
      else $error("write without lane 0 changed a register");

    a_wr_okay: assert property (
      s_wr_to(PPC_LATCH_OFS[p]) |=> bvalid && bresp == PPC_RESP_OKAY)
      else $error("latch write refused");

    a_latch_read: assert property (
      s_rd_take(PPC_LATCH_OFS[p])
      |=> rvalid && rresp == PPC_RESP_OKAY
      && rdata[7:0] == $past(pin_level[p]))
      else $error("latch read does not return pins");

    a_cfg_lo_read: assert property (
      s_rd_take(PPC_CFG_LO_OFS[p])
      |=> rvalid && rdata[7:0] == $past(st_reg.cfg_lo[p]))
      else $error("config low read wrong");

    a_cfg_hi_read: assert property (
      s_rd_take(PPC_CFG_HI_OFS[p])
      |=> rvalid && rdata[7:0] == $past(st_reg.cfg_hi[p]))
      else $error("config high read wrong");
  end
endmodule : ppc_port_block

// file: design/ppc_pkg.sv
// constants, types and drive function for the parallel port block
// How it works
// - port 1 latch, eight bits, one per pin; writes drive, reads see pins.
// - port 2 latch, eight bits, tied bit for bit to its pins.
// - port 3 latch; top three bits reach pins only on large package.
// - port 0 pin n mode from bit n of high:low config pair.
// - port 1 pin n mode from bit n of its config pair.
// - port 2 pin n mode: 00 od, 01 quasi, 10 hi-z, 11 push-pull.
// - port 3 pin n mode uses same four-way encoding.
// - port 0 latch, eight bits, pins governed by port 0 config pair.
package ppc_pkg;
  localparam int PPC_PORTS = 4;
  localparam int PPC_W = 8;
  localparam int PPC_AW = 6;
  // register map, byte addresses of aligned 32-bit words
  localparam logic [5:0] PPC_LATCH_OFS [PPC_PORTS] =
    '{6'h00, 6'h04, 6'h08, 6'h0C};
  localparam logic [5:0] PPC_CFG_LO_OFS [PPC_PORTS] =
    '{6'h10, 6'h18, 6'h20, 6'h28};
  localparam logic [5:0] PPC_CFG_HI_OFS [PPC_PORTS] =
    '{6'h14, 6'h1C, 6'h24, 6'h2C};
  // reset values: latches high, every pin quasi-bidirectional
  localparam logic [7:0] PPC_LATCH_RST = 8'hFF;
  localparam logic [7:0] PPC_CFG_LO_RST = 8'hFF;
  localparam logic [7:0] PPC_CFG_HI_RST = 8'h00;
  // port 3 pins that exist on every package
  localparam int PPC_P3 = 3;
  localparam logic [7:0] PPC_P3_SMALL_MASK = 8'h1F;
  localparam logic [7:0] PPC_ALL_PINS = 8'hFF;
  // bus answers
  localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPC_RESP_SLVERR = 2'h2;
  localparam logic [23:0] PPC_RDATA_PAD = 24'h000000;

  typedef enum logic [1:0] {
    PPC_OPEN_DRAIN = 2'h0,
    PPC_QUASI = 2'h1,
    PPC_HIGH_Z = 2'h2,
    PPC_PUSH_PULL = 2'h3
  } ppc_mode_type;

  // returns {drive level, output enable, weak pull-up enable}
  function automatic logic [2:0] ppc_drive(input ppc_mode_type mode,
                                            input logic level);
    logic [2:0] res;
    res = 3'h0;
    case (mode)
      PPC_OPEN_DRAIN: res = {1'b0, ~level, 1'b0};
      PPC_QUASI: res = {1'b0, ~level, level};
      PPC_HIGH_Z: res = 3'h0;
      PPC_PUSH_PULL: res = {level, 1'b1, 1'b0};
      default: res = 3'h0;
    endcase
    return res;
  endfunction : ppc_drive
endpackage : ppc_pkg

// file: design/ppc_pin_drive.sv
// registered pin driver for one eight-bit port
`timescale 1ns/100ps
module ppc_pin_drive
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // latch and configuration
  input wire logic [7:0] latch,
  input wire logic [7:0] cfg_lo,
  input wire logic [7:0] cfg_hi,
  input wire logic [7:0] pin_avail,
  // pin drivers
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pu
);
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } ppc_drv_type;

  ppc_drv_type drv_reg;
  ppc_drv_type drv_next;
  logic [7:0] bit_out;
  logic [7:0] bit_oe;
  logic [7:0] bit_pu;

  // each pin: mode code is {high bit, low bit} of the config pair
  for (genvar i = 0; i < PPC_W; i++) begin : g_pin
    logic [2:0] d;
    assign d = ppc_drive(ppc_mode_type'({cfg_hi[i], cfg_lo[i]}), latch[i]);
    // missing package pins are never driven
    assign bit_out[i] = d[2] & pin_avail[i];
    assign bit_oe[i] = d[1] & pin_avail[i];
    assign bit_pu[i] = d[0] & pin_avail[i];
  end

  always_comb begin
    drv_next.out = bit_out;
    drv_next.oe = bit_oe;
    drv_next.pu = bit_pu;
  end

  // registered so the pins never see decode glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_reg <= '0;
    end else begin
      drv_reg <= drv_next;
    end
  end

  assign pin_out = drv_reg.out;
  assign pin_oe = drv_reg.oe;
  assign pin_pu = drv_reg.pu;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  for (genvar i = 0; i < PPC_W; i++) begin : g_chk
    a_od_low: assert property (
      pin_avail[i] && {cfg_hi[i], cfg_lo[i]} == PPC_OPEN_DRAIN && !latch[i]
      |=> pin_oe[i] && !pin_out[i] && !pin_pu[i])
      else $error("open-drain zero not driven low");
    // not from the release edge: the pins still hold their reset state then
    a_quasi_pull: assert property (
      aresetn && pin_avail[i] && {cfg_hi[i], cfg_lo[i]} == PPC_QUASI
      && latch[i] |=> !pin_oe[i] && pin_pu[i])
      else $error("quasi one lacks pull-up");
    a_push_level: assert property (
      pin_avail[i] && {cfg_hi[i], cfg_lo[i]} == PPC_PUSH_PULL
      |=> pin_oe[i] && pin_out[i] == $past(latch[i]))
      else $error("push-pull level wrong");
    a_hiz_off: assert property (
      {cfg_hi[i], cfg_lo[i]} == PPC_HIGH_Z |=> !pin_oe[i] && !pin_pu[i])
      else $error("high-impedance pin driven");
  end
endmodule : ppc_pin_drive

// file: design/ppc_read_mux.sv
// register read decode for the port block
`timescale 1ns/100ps
module ppc_read_mux
  import ppc_pkg::*;
(
  // address
  input wire logic [5:0] addr,
  // sources
  input wire logic [3:0][7:0] pin_level,
  input wire logic [3:0][7:0] cfg_lo,
  input wire logic [3:0][7:0] cfg_hi,
  // result
  output logic [7:0] data,
  output logic hit
);
  // latch addresses return the pin level, as a port read does
  always_comb begin
    data = 8'h00;
    hit = 1'b0;
    for (int p = 0; p < PPC_PORTS; p++) begin
      if (addr == PPC_LATCH_OFS[p]) begin
        data = pin_level[p];
        hit = 1'b1;
      end
      if (addr == PPC_CFG_LO_OFS[p]) begin
        data = cfg_lo[p];
        hit = 1'b1;
      end
      if (addr == PPC_CFG_HI_OFS[p]) begin
        data = cfg_hi[p];
        hit = 1'b1;
      end
    end
  end
endmodule : ppc_read_mux

// file: bench/ppc_board.sv
// board model that resolves the levels on the port pins
`timescale 1ns/100ps
module ppc_board
(
  // clock
  input wire logic aclk,
  // block pin drivers
  input wire logic [3:0][7:0] pin_out,
  input wire logic [3:0][7:0] pin_oe,
  input wire logic [3:0][7:0] pin_pu,
  // external source on each pin
  input wire logic [3:0][7:0] ext_en,
  input wire logic [3:0][7:0] ext_val,
  // level seen by the block
  output logic [3:0][7:0] pin_in
);
  logic flt_reg;
  // an undriven pin with no pull-up toggles, so no stale level passes
  initial flt_reg = 1'b0;
  always @(posedge aclk) flt_reg <= ~flt_reg;
  // block driver first, then the external source, then the weak pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pin_pu | {32{flt_reg}}));
endmodule : ppc_board

// file: bench/tb.sv
// self-checking bench for the port block
`timescale 1ns/100ps
module tb;
  import ppc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d, ds, rdata_s;
  logic [3:0][7:0] pin_in, pin_out, pin_oe, pin_pu;
  logic [3:0][7:0] pin_out_s, pin_oe_s, pin_pu_s;
  logic [3:0][7:0] ext_en = '0, ext_val = '0;
  int errors = 0, compares = 0, cycles = 0;
  logic [7:0] lo_tab [5] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h0F};
  logic [7:0] hi_tab [5] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h33};

  ppc_port_block i_ppc_port_block (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu(pin_pu));
  ppc_board i_ppc_board (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pu(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // small-package twin on the same bus; same timing, so its answers line up
  ppc_port_block #(.LARGE_PACKAGE(1'b0)) i_ppc_port_block_small (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
    .bresp(), .bvalid(), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(), .rdata(rdata_s), .rresp(), .rvalid(),
    .rready(rready), .pin_in(pin_in), .pin_out(pin_out_s),
    .pin_oe(pin_oe_s), .pin_pu(pin_pu_s));

  // 250 MHz clock
  always #2 aclk = ~aclk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // write: address and data offered together, each dropped when taken
  // lag: cycles the answer is left waiting before ready is raised
  task automatic wr(input logic [5:0] a, input logic [7:0] v,
                    input int lag = 0);
    int n;
    n = lag;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (bvalid && n > 0) n--;
      else if (bvalid) bready <= 1'b1;
    end
  endtask : wr

  task automatic rd(input logic [5:0] a, input int lag = 0);
    int n;
    n = lag;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        r = rresp;
        d = rdata;
        ds = rdata_s;
        rready <= 1'b0;
        break;
      end
      if (rvalid && n > 0) n--;
      else if (rvalid) rready <= 1'b1;
    end
  endtask : rd

  // expected {out, oe, pu}; mode bit pair is {hi, lo}
  function automatic logic [23:0] expd(logic [7:0] lo, hi, l);
    logic [7:0] pp, od, qs;
    pp = lo & hi;
    od = ~lo & ~hi;
    qs = lo & ~hi;
    return {pp & l, pp | ((od | qs) & ~l), qs & l};
  endfunction : expd

  task automatic t_reset();
    for (int p = 0; p < 4; p++) begin
      rd(PPC_CFG_LO_OFS[p]);
      chk("cfg_low reset", {24'h0, PPC_CFG_LO_RST}, d);
      chk("read resp", {30'h0, PPC_RESP_OKAY}, {30'h0, r});
      rd(PPC_CFG_HI_OFS[p]);
      chk("cfg_high reset", {24'h0, PPC_CFG_HI_RST}, d);
      chk("pins reset", {8'h00, 8'h00, 8'hFF},
          {pin_out[p], pin_oe[p], pin_pu[p]});
    end
    chk("small port3 pull-up", {24'h0, PPC_P3_SMALL_MASK},
        {24'h0, pin_pu_s[PPC_P3]});
  endtask : t_reset

  // every code on every port, plus a mix of codes across the bits
  task automatic t_modes();
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 5; c++) begin
        wr(PPC_LATCH_OFS[p], 8'h5A);
        wr(PPC_CFG_LO_OFS[p], lo_tab[c]);
        wr(PPC_CFG_HI_OFS[p], hi_tab[c]);
        repeat (2) @(posedge aclk);
        chk("pin drive", {8'h00, expd(lo_tab[c], hi_tab[c], 8'h5A)},
            {8'h00, pin_out[p], pin_oe[p], pin_pu[p]});
        if (p == PPC_P3)
          chk("small pin drive", {8'h00, expd(lo_tab[c], hi_tab[c], 8'h5A)
              & {3{PPC_P3_SMALL_MASK}}}, {8'h00, pin_out_s[p], pin_oe_s[p],
              pin_pu_s[p]});
      end
    end
  endtask : t_modes

  // latch drives the pins, a read returns what is on them
  task automatic t_readback();
    for (int p = 0; p < 4; p++) begin
      wr(PPC_CFG_LO_OFS[p], 8'hFF);
      wr(PPC_CFG_HI_OFS[p], 8'hFF);
      wr(PPC_LATCH_OFS[p], 8'hA5);
      chk("write resp", {30'h0, PPC_RESP_OKAY}, {30'h0, r});
      rd(PPC_LATCH_OFS[p]);
      chk("latch drive read", 32'h000000A5, d);
      if (p == PPC_P3)
        chk("small pin read", {24'h0, 8'hA5 & PPC_P3_SMALL_MASK}, ds);
      wr(PPC_CFG_LO_OFS[p], 8'h00);
      ext_en[p] <= 8'hFF;
      ext_val[p] <= 8'h3C;
      rd(PPC_LATCH_OFS[p]);
      chk("external pin read", 32'h0000003C, d);
      if (p == PPC_P3)
        chk("small ext read", {24'h0, 8'h3C & PPC_P3_SMALL_MASK}, ds);
      ext_en[p] <= 8'h00;
    end
  endtask : t_readback

  // unmapped places answer with an error both ways
  task automatic t_unmapped();
    wr(6'h30, 8'h77, 3);
    chk("unmapped write resp", {30'h0, PPC_RESP_SLVERR}, {30'h0, r});
    rd(6'h3C, 3);
    chk("unmapped read resp", {30'h0, PPC_RESP_SLVERR}, {30'h0, r});
    // a write without byte lane 0 is answered but changes nothing
    wstrb <= 4'hE;
    wr(PPC_CFG_LO_OFS[0], 8'hFF);
    chk("masked write resp", {30'h0, PPC_RESP_OKAY}, {30'h0, r});
    wstrb <= 4'hF;
    rd(PPC_CFG_LO_OFS[0]);
    chk("masked write kept", 32'h00000000, d);
  endtask : t_unmapped

  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_modes();
    t_readback();
    t_unmapped();
    report_and_stop();
  end
endmodule : tb
